// [src/sabc_pkg.sv]
// Purpose: Shared constants, role encodings and helpers for the
//          second alert output block.
// Assumes: One system clock; status logic sits in the same domain.
// Notes:   Flag vectors are ordered so that flag k pairs with
//          enable bit k + FLAG_BASE_BIT of the config register.
package sabc_pkg;

	// Register map
	localparam logic [7:0] ADDR_ALERT_PIN_TWO_CONFIG = 8'hd6;
	localparam logic [15:0] ALERT_PIN_TWO_CONFIG_RESET = 16'h0004;
	localparam int CONFIG_WIDTH = 16;
	localparam int ADDR_WIDTH = 8;

	// Field positions
	localparam int POLARITY_BIT = 0;
	localparam int ROLE_LSB = 1;
	localparam int ROLE_MSB = 2;
	localparam int FLAG_BASE_BIT = 3;
	localparam int NUM_FLAGS = 13;

	// Enable bit positions, one per status flag
	localparam int EN_OVERPOWER_WARN_BIT = 3;
	localparam int EN_CURRENT_LIMIT_BIT = 4;
	localparam int EN_AUX_UNDERVOLT_WARN_BIT = 5;
	localparam int EN_AUX_OVERVOLT_WARN_BIT = 6;
	localparam int EN_INPUT_UNDERVOLT_WARN_BIT = 7;
	localparam int EN_INPUT_OVERVOLT_WARN_BIT = 8;
	localparam int EN_CURRENT_WARN_B_BIT = 9;
	localparam int EN_OVERCURRENT_WARN_BIT = 10;
	localparam int EN_COMM_LOGIC_ERROR_BIT = 11;
	localparam int EN_INPUT_UNDERVOLT_FAULT_BIT = 12;
	localparam int EN_INPUT_OVERVOLT_FAULT_BIT = 13;
	localparam int EN_OVERCURRENT_FAULT_BIT = 14;
	localparam int EN_SWITCH_FAULT_BIT = 15;

	// Role field codes
	localparam logic [1:0] ROLE_CODE_ALERT = 2'h0;
	localparam logic [1:0] ROLE_CODE_GPO = 2'h1;
	localparam logic [1:0] ROLE_CODE_RETRY = 2'h2;
	localparam logic [1:0] ROLE_CODE_COMPARE = 2'h3;

	// Pin level while idle and out of reset
	localparam logic PIN_RESET = 1'b1;

	typedef enum logic [3:0] {
		SABC_ROLE_ALERT = 4'b0001,
		SABC_ROLE_GPO = 4'b0010,
		SABC_ROLE_RETRY = 4'b0100,
		SABC_ROLE_COMPARE = 4'b1000
	} sabc_role_e;

	localparam sabc_role_e ROLE_RESET = SABC_ROLE_RETRY;

	// OR of the flags whose enable is set
	function automatic logic masked_any(
		input logic [NUM_FLAGS-1:0] flags,
		input logic [NUM_FLAGS-1:0] enables
	);
		return |(flags & enables);
	endfunction

endpackage

// [src/sabc_cfg_reg.sv]
// Purpose: Holds the second alert output configuration word.
// Assumes: Write strobe is already address-decoded, one cycle wide.
// Notes:   Also remembers whether software has ever written the word.
`timescale 1ns/1ps
`default_nettype none
module sabc_cfg_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VALUE = 16'h0004
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic [WIDTH-1:0] o_value,
	output logic o_written
);
	logic [WIDTH-1:0] value_reg;
	logic [WIDTH-1:0] value_next;
	logic written_reg;
	logic written_next;

	// A write replaces the whole word; no bit is reserved
	always_comb begin
		value_next = value_reg;
		written_next = written_reg;
		if (i_wr_en) begin
			value_next = i_wdata;
			written_next = 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			value_reg <= RESET_VALUE;
			written_reg <= 1'b0;
		end else begin
			value_reg <= value_next;
			written_reg <= written_next;
		end
	end

	assign o_value = value_reg;
	assign o_written = written_reg;
endmodule
`default_nettype wire

// [src/sabc_alert_merge.sv]
// Purpose: Gates latched and live status flags by their enables.
// Assumes: Flags come from logic on the same clock.
// Notes:   Both results are registered, one cycle behind the flags.
`timescale 1ns/1ps
`default_nettype none
module sabc_alert_merge
	import sabc_pkg::*;
#(
	parameter int FLAG_COUNT = sabc_pkg::NUM_FLAGS
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic [FLAG_COUNT-1:0] i_enable,
	input wire logic [FLAG_COUNT-1:0] i_latched,
	input wire logic [FLAG_COUNT-1:0] i_live,
	output logic o_latched_any,
	output logic o_live_any
);
	logic latched_any_reg;
	logic latched_any_next;
	logic live_any_reg;
	logic live_any_next;

	// Same mask for both views, so the comparator role mirrors alerts
	always_comb begin
		latched_any_next = masked_any(i_latched, i_enable);
		live_any_next = masked_any(i_live, i_enable);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			latched_any_reg <= 1'b0;
			live_any_reg <= 1'b0;
		end else begin
			latched_any_reg <= latched_any_next;
			live_any_reg <= live_any_next;
		end
	end

	assign o_latched_any = latched_any_reg;
	assign o_live_any = live_any_reg;
endmodule
`default_nettype wire

// [src/sabc_second_alert_output.sv]
// Purpose: Second output pin of a hot swap monitor: alert enables,
//          role select and pin drive.
// Assumes: Command port is driven by the serial interface on i_mclk.
// Notes:   Pin is active low in alert, retry-fail and comparator roles.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Bit 15 gates switch-fault flag onto alert
// - Switch-fault alert works before any software write
// - Bit 14 gates overcurrent fault onto alert
// - Bit 13 gates input overvoltage fault
// - Bit 12 gates input undervoltage fault
// - Bit 11 gates comm, memory, logic error
// - Bit 10 gates overcurrent warning
// - Bit 9 gates second current warning
// - Bit 8 gates input overvoltage warning
// - Bit 7 gates input undervoltage warning
// - Bit 6 gates auxiliary overvoltage warning
// - Bit 5 gates auxiliary undervoltage warning
// - Bit 4 gates current-limit fault
// - Bit 3 gates input overpower warning
// - Config resets to 0x0004, retry-fail role
// - Role 00 makes pin the alert signal
// - Role 01 makes pin a software output
// - Role 10 shows retry failure, reset default
// - Role 11 follows live unlatched flags
// - Polarity bit sets software output level
module sabc_second_alert_output
	import sabc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [sabc_pkg::ADDR_WIDTH-1:0] i_reg_addr,
	input wire logic [sabc_pkg::CONFIG_WIDTH-1:0] i_reg_wdata,
	input wire logic [sabc_pkg::NUM_FLAGS-1:0] i_latched_flags,
	input wire logic [sabc_pkg::NUM_FLAGS-1:0] i_live_flags,
	input wire logic i_retry_failed,
	output logic [sabc_pkg::CONFIG_WIDTH-1:0] o_reg_rdata,
	output logic o_reg_ack,
	output logic o_reg_nak,
	output logic o_alert_request,
	output logic o_second_output_pin
);
	localparam int IDX_OVERPOWER_WARN =
		EN_OVERPOWER_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_CURRENT_LIMIT =
		EN_CURRENT_LIMIT_BIT - FLAG_BASE_BIT;
	localparam int IDX_AUX_UNDERVOLT_WARN =
		EN_AUX_UNDERVOLT_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_AUX_OVERVOLT_WARN =
		EN_AUX_OVERVOLT_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_INPUT_UNDERVOLT_WARN =
		EN_INPUT_UNDERVOLT_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_INPUT_OVERVOLT_WARN =
		EN_INPUT_OVERVOLT_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_CURRENT_WARN_B =
		EN_CURRENT_WARN_B_BIT - FLAG_BASE_BIT;
	localparam int IDX_OVERCURRENT_WARN =
		EN_OVERCURRENT_WARN_BIT - FLAG_BASE_BIT;
	localparam int IDX_COMM_LOGIC_ERROR =
		EN_COMM_LOGIC_ERROR_BIT - FLAG_BASE_BIT;
	localparam int IDX_INPUT_UNDERVOLT_FAULT =
		EN_INPUT_UNDERVOLT_FAULT_BIT - FLAG_BASE_BIT;
	localparam int IDX_INPUT_OVERVOLT_FAULT =
		EN_INPUT_OVERVOLT_FAULT_BIT - FLAG_BASE_BIT;
	localparam int IDX_OVERCURRENT_FAULT =
		EN_OVERCURRENT_FAULT_BIT - FLAG_BASE_BIT;
	localparam int IDX_SWITCH_FAULT =
		EN_SWITCH_FAULT_BIT - FLAG_BASE_BIT;

	logic [CONFIG_WIDTH-1:0] cfg_q;
	logic cfg_written;
	logic cfg_hit;
	logic cfg_wr;
	logic [NUM_FLAGS-1:0] eff_enable;
	logic latched_any;
	logic live_any;
	sabc_role_e role_reg;
	sabc_role_e role_next;
	logic pin_reg;
	logic pin_next;
	logic [CONFIG_WIDTH-1:0] rdata_reg;
	logic [CONFIG_WIDTH-1:0] rdata_next;
	logic ack_reg;
	logic ack_next;
	logic nak_reg;
	logic nak_next;

	// Only one command code belongs to this block
	assign cfg_hit = (i_reg_addr == ADDR_ALERT_PIN_TWO_CONFIG);
	assign cfg_wr = i_reg_wr & cfg_hit;

	sabc_cfg_reg #(
		.WIDTH(CONFIG_WIDTH),
		.RESET_VALUE(ALERT_PIN_TWO_CONFIG_RESET)
	) u_cfg (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_wr_en(cfg_wr),
		.i_wdata(i_reg_wdata),
		.o_value(cfg_q),
		.o_written(cfg_written)
	);

	// Switch fault stays armed until the first write, so a bad pass
	// device is flagged even while software is still booting
	assign eff_enable[IDX_SWITCH_FAULT] =
		cfg_q[EN_SWITCH_FAULT_BIT] | ~cfg_written;
	assign eff_enable[IDX_OVERCURRENT_FAULT] =
		cfg_q[EN_OVERCURRENT_FAULT_BIT];
	assign eff_enable[IDX_INPUT_OVERVOLT_FAULT] =
		cfg_q[EN_INPUT_OVERVOLT_FAULT_BIT];
	assign eff_enable[IDX_INPUT_UNDERVOLT_FAULT] =
		cfg_q[EN_INPUT_UNDERVOLT_FAULT_BIT];
	assign eff_enable[IDX_COMM_LOGIC_ERROR] =
		cfg_q[EN_COMM_LOGIC_ERROR_BIT];
	assign eff_enable[IDX_OVERCURRENT_WARN] =
		cfg_q[EN_OVERCURRENT_WARN_BIT];
	assign eff_enable[IDX_CURRENT_WARN_B] =
		cfg_q[EN_CURRENT_WARN_B_BIT];
	assign eff_enable[IDX_INPUT_OVERVOLT_WARN] =
		cfg_q[EN_INPUT_OVERVOLT_WARN_BIT];
	assign eff_enable[IDX_INPUT_UNDERVOLT_WARN] =
		cfg_q[EN_INPUT_UNDERVOLT_WARN_BIT];
	assign eff_enable[IDX_AUX_OVERVOLT_WARN] =
		cfg_q[EN_AUX_OVERVOLT_WARN_BIT];
	assign eff_enable[IDX_AUX_UNDERVOLT_WARN] =
		cfg_q[EN_AUX_UNDERVOLT_WARN_BIT];
	assign eff_enable[IDX_CURRENT_LIMIT] =
		cfg_q[EN_CURRENT_LIMIT_BIT];
	assign eff_enable[IDX_OVERPOWER_WARN] =
		cfg_q[EN_OVERPOWER_WARN_BIT];

	sabc_alert_merge #(
		.FLAG_COUNT(NUM_FLAGS)
	) u_merge (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_enable(eff_enable),
		.i_latched(i_latched_flags),
		.i_live(i_live_flags),
		.o_latched_any(latched_any),
		.o_live_any(live_any)
	);

	// Alert request to the serial side exists in every role
	assign o_alert_request = latched_any;

	// Role decode of the two-bit field
	always_comb begin
		case (cfg_q[ROLE_MSB:ROLE_LSB])
			ROLE_CODE_ALERT: role_next = SABC_ROLE_ALERT;
			ROLE_CODE_GPO: role_next = SABC_ROLE_GPO;
			ROLE_CODE_RETRY: role_next = SABC_ROLE_RETRY;
			ROLE_CODE_COMPARE: role_next = SABC_ROLE_COMPARE;
			default: role_next = ROLE_RESET;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			role_reg <= ROLE_RESET;
		end else begin
			role_reg <= role_next;
		end
	end

	// Pin level per role; registered so the pin never glitches
	always_comb begin
		case (role_reg)
			SABC_ROLE_ALERT: pin_next = ~latched_any;
			SABC_ROLE_GPO: pin_next = cfg_q[POLARITY_BIT];
			SABC_ROLE_RETRY: pin_next = ~i_retry_failed;
			SABC_ROLE_COMPARE: pin_next = ~live_any;
			default: pin_next = PIN_RESET;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pin_reg <= PIN_RESET;
		end else begin
			pin_reg <= pin_next;
		end
	end

	assign o_second_output_pin = pin_reg;

	// Command answer: a read returns the word before a same-cycle write
	always_comb begin
		rdata_next = '0;
		ack_next = 1'b0;
		nak_next = 1'b0;
		if (i_reg_rd | i_reg_wr) begin
			if (cfg_hit) begin
				ack_next = 1'b1;
				if (i_reg_rd) begin
					rdata_next = cfg_q;
				end
			end else begin
				nak_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rdata_reg <= '0;
			ack_reg <= 1'b0;
			nak_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			nak_reg <= nak_next;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_reg_ack = ack_reg;
	assign o_reg_nak = nak_reg;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_role_is(logic [1:0] code);
		cfg_q[ROLE_MSB:ROLE_LSB] == code;
	endsequence

	property p_reset_value;
		$past(i_sys_rst) |->
			(cfg_q == ALERT_PIN_TWO_CONFIG_RESET) && o_second_output_pin;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("config word not at reset value after reset");

	property p_switch_masked;
		(cfg_written && !cfg_q[EN_SWITCH_FAULT_BIT] &&
			(i_latched_flags == (13'h0001 << IDX_SWITCH_FAULT)))
			|=> !o_alert_request;
	endproperty
	a_switch_masked: assert property (p_switch_masked)
		else $error("disabled switch fault raised an alert");

	property p_switch_early;
		(!cfg_written && i_latched_flags[IDX_SWITCH_FAULT])
			|=> o_alert_request;
	endproperty
	a_switch_early: assert property (p_switch_early)
		else $error("switch fault not alerting before first write");

	generate
		for (genvar k = 0; k < NUM_FLAGS - 1; k++) begin : g_en
			property p_en_raises;
				(cfg_q[k + FLAG_BASE_BIT] && i_latched_flags[k])
					|=> o_alert_request;
			endproperty
			a_en_raises: assert property (p_en_raises)
				else $error("enabled flag did not raise the alert");

			property p_cmp_follow;
				(s_role_is(ROLE_CODE_COMPARE) and
					(cfg_q[k + FLAG_BASE_BIT] && i_live_flags[k]))
					|-> ##2 !o_second_output_pin;
			endproperty
			a_cmp_follow: assert property (p_cmp_follow)
				else $error("comparator pin missed a live flag");
		end
	endgenerate

	property p_en_clear;
		((i_latched_flags & eff_enable) == '0) |=> !o_alert_request;
	endproperty
	a_en_clear: assert property (p_en_clear)
		else $error("alert raised with no enabled flag set");

	sequence s_alert_cause;
		s_role_is(ROLE_CODE_ALERT) and
			masked_any(i_latched_flags, eff_enable);
	endsequence

	property p_alert_low;
		s_alert_cause |-> ##2 !o_second_output_pin;
	endproperty
	a_alert_low: assert property (p_alert_low)
		else $error("alert role pin not low on enabled flag");

	property p_alert_release;
		(s_role_is(ROLE_CODE_ALERT) and
			!masked_any(i_latched_flags, eff_enable))
			|-> ##2 o_second_output_pin;
	endproperty
	a_alert_release: assert property (p_alert_release)
		else $error("alert role pin held low with no cause");

	property p_gpo_level;
		s_role_is(ROLE_CODE_GPO) ##1 s_role_is(ROLE_CODE_GPO)
			|=> o_second_output_pin == $past(cfg_q[POLARITY_BIT]);
	endproperty
	a_gpo_level: assert property (p_gpo_level)
		else $error("software output does not follow polarity bit");

	property p_retry_fail;
		s_role_is(ROLE_CODE_RETRY) ##1 1'b1
			|=> o_second_output_pin == !$past(i_retry_failed);
	endproperty
	a_retry_fail: assert property (p_retry_fail)
		else $error("retry-fail role pin wrong");

	property p_cmp_release;
		(s_role_is(ROLE_CODE_COMPARE) and
			!masked_any(i_live_flags, eff_enable))
			|-> ##2 o_second_output_pin;
	endproperty
	a_cmp_release: assert property (p_cmp_release)
		else $error("comparator pin low with no live flag");

	property p_write_read;
		(cfg_wr && !i_reg_rd) ##1 (i_reg_rd && cfg_hit && !i_reg_wr)
			|=> o_reg_ack && (o_reg_rdata == $past(i_reg_wdata, 2));
	endproperty
	a_write_read: assert property (p_write_read)
		else $error("read back differs from written word");

	property p_unmapped;
		((i_reg_rd || i_reg_wr) && !cfg_hit)
			|=> o_reg_nak && !o_reg_ack && (o_reg_rdata == '0);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped command not refused");
endmodule
`default_nettype wire

// [bench/sabc_host_model.sv]
// Purpose: Host side that watches the second output pin.
// Assumes: Host samples the pin on the system clock.
// Notes:   Observer only; it counts low-going edges and drives nothing.
`timescale 1ns/1ps
`default_nettype none
module sabc_host_model (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_pin,
	output var int o_low_edges
);
	logic last_reg;
	logic last_next;
	int cnt_next;
	// Edge count; a released pin idles high so reset assumes high
	always_comb begin
		last_next = i_pin;
		cnt_next = o_low_edges + ((last_reg && !i_pin) ? 1 : 0);
	end
	// Registers only
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			last_reg <= 1'b1;
			o_low_edges <= 0;
		end else begin
			last_reg <= last_next;
			o_low_edges <= cnt_next;
		end
	end
endmodule
`default_nettype wire

// [bench/tb_sabc_second_alert_output.sv]
// Purpose: Self-checking bench for the second alert output block.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes:   Outputs are compared three edges after any change, which
//          covers the longest path from a config write to the pin.
`timescale 1ns/1ps
`default_nettype none
module tb_sabc_second_alert_output;
	import sabc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wd = 16'h0000;
	logic [12:0] lat = 13'h0000;
	logic [12:0] live = 13'h0000;
	logic retry = 1'b0;
	logic [15:0] rdata;
	logic ack;
	logic nak;
	logic areq;
	logic pin;
	int host_lows;
	int n_mismatch = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h4ecf5753;
	// Reference word and whether software has written it yet
	logic [15:0] m_cfg = ALERT_PIN_TWO_CONFIG_RESET;
	bit m_wr = 1'b0;

	sabc_second_alert_output i_dut (
		.i_mclk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wd), .i_latched_flags(lat),
		.i_live_flags(live), .i_retry_failed(retry),
		.o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_nak(nak),
		.o_alert_request(areq), .o_second_output_pin(pin)
	);
	sabc_host_model i_host (
		.i_mclk(clk), .i_sys_rst(rst), .i_pin(pin),
		.o_low_edges(host_lows)
	);

	// Free-running system clock
	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected {alert request, pin}; switch enable counts until a write
	function automatic logic [1:0] exp_out();
		logic [12:0] en;
		logic la;
		logic p;
		en = m_cfg[15:3] | (m_wr ? 13'h0000 : 13'h1000);
		la = |(lat & en);
		case (m_cfg[2:1])
			2'h0: p = ~la;
			2'h1: p = m_cfg[0];
			2'h2: p = ~retry;
			default: p = ~(|(live & en));
		endcase
		return {la, p};
	endfunction

	task automatic chk_out();
		chk_reg({14'h0000, areq, pin}, {14'h0000, exp_out()});
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	// One command; strobe held for exactly the taking edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		logic hit;
		hit = (a == ADDR_ALERT_PIN_TWO_CONFIG);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		// Answer stands only in the cycle after the taking edge
		#1;
		q = rdata;
		chk_reg({14'h0000, ack, nak}, {14'h0000, hit, ~hit});
		if (w && hit) begin
			m_cfg = d;
			m_wr = 1'b1;
		end
	endtask

	task automatic rd_chk(input logic [7:0] a);
		logic [15:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk_reg(q, (a == ADDR_ALERT_PIN_TWO_CONFIG) ? m_cfg : 16'h0000);
	endtask

	task automatic wr_cfg(input logic [15:0] d);
		logic [15:0] q;
		bus(1'b1, ADDR_ALERT_PIN_TWO_CONFIG, d, q);
		settle();
	endtask

	// Write, then read back on the very next edge with no idle gap
	task automatic wr_rd(input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		rd <= 1'b0;
		addr <= ADDR_ALERT_PIN_TWO_CONFIG;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		#1;
		chk_reg({14'h0000, ack, nak}, 16'h0002);
		m_cfg = d;
		m_wr = 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg({14'h0000, ack, nak}, 16'h0002);
		chk_reg(rdata, m_cfg);
		settle();
	endtask

	task automatic setf(input logic [12:0] l, input logic [12:0] v,
		input logic r);
		@(posedge clk);
		lat <= l;
		live <= v;
		retry <= r;
		settle();
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog, many times the expected run of about 460 cycles
	initial begin
		repeat (8000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end

	// Main sequence
	initial begin
		logic [15:0] q;
		logic [31:0] r;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_chk(ADDR_ALERT_PIN_TWO_CONFIG);
		setf(13'h1000, 13'h0000, 1'b1);
		chk_out();
		setf(13'h0fff, 13'h1fff, 1'b0);
		chk_out();
		$display("test reset done");
		// Unmapped commands are refused and leave the word alone
		bus(1'b1, 8'hd7, 16'hffff, q);
		rd_chk(8'hd5);
		rd_chk(ADDR_ALERT_PIN_TWO_CONFIG);
		$display("test unmapped done");
		// One enable at a time; the other twelve flags must not leak
		for (int k = 0; k < 13; k++) begin
			wr_cfg(16'h0008 << k);
			setf(13'h0001 << k, 13'h0000, 1'b1);
			chk_out();
			setf(~(13'h0001 << k), 13'h1fff, 1'b1);
			chk_out();
		end
		// Once written, a clear bit 15 masks the switch fault alone
		wr_cfg(16'h0008);
		setf(13'h1000, 13'h0000, 1'b1);
		chk_out();
		$display("test enables done");
		// Software output, both polarities, all enables set
		wr_cfg(16'hfffa);
		chk_out();
		wr_cfg(16'hfffb);
		chk_out();
		// Comparator follows live flags, ignores latched ones
		wr_cfg(16'hfffe);
		setf(13'h1fff, 13'h0000, 1'b1);
		chk_out();
		setf(13'h0000, 13'h0400, 1'b0);
		chk_out();
		$display("test roles done");
		// Random words and flags across every role
		for (int i = 0; i < 24; i++) begin
			r = xs();
			wr_rd(r[15:0]);
			r = xs();
			setf(r[12:0], r[25:13], r[26]);
			chk_out();
		end
		chk_reg(16'(host_lows != 0), 16'h0001);
		$display("test random done");
		finish_test();
	end
endmodule
`default_nettype wire
